// ---- adr_consts.vh ----
// Timing, width and encoding constants for the strobe memory controller
`ifndef ADR_CONSTS_VH
`define ADR_CONSTS_VH

`define ADR_CLK_PERIOD_PS 8000
`define ADR_ADDR_BITS 18
`define ADR_PIN_BITS 9
`define ADR_ROW_COUNT 512
// Minimum intervals in picoseconds
`define ADR_ROW_PRECHARGE_TIME_PS 75000
`define ADR_ROW_PULSE_WIDTH_PS 80000
`define ADR_COLUMN_PULSE_WIDTH_PS 30000
`define ADR_ROW_TO_COLUMN_DELAY_PS 25000
`define ADR_ROW_ADDR_HOLD_PS 15000
`define ADR_COLUMN_PRECHARGE_PS 15000
`define ADR_REFRESH_SETUP_PS 10000
`define ADR_REFRESH_HOLD_PS 25000
`define ADR_ACCESS_FROM_ROW_STROBE_PS 80000
`define ADR_ACCESS_FROM_COLUMN_STROBE_PS 30000
`define ADR_ROW_TO_STORE_DELAY_PS 80000
`define ADR_COLUMN_TO_STORE_DELAY_PS 25000
`define ADR_STORE_PULSE_PS 15000
// Refresh interval and power-up pause
`define ADR_REFRESH_PERIOD_US 4000
`define ADR_POWER_UP_PAUSE_US 100
`define ADR_INIT_CYCLES 4'h8
`define ADR_CLK_MHZ 125
// Command encodings on req_op
`define ADR_OP_READ 2'h0
`define ADR_OP_WRITE 2'h1
`define ADR_OP_RMW 2'h2
`define ADR_CNT_BITS 20

`endif

// ---- adr_interval.v ----
// Down-counter that times one strobe interval
`timescale 1ns/10ps
`include "adr_consts.vh"

module adr_interval #(
  parameter W = `ADR_CNT_BITS
) (
  input wire clk,
  input wire sys_rst,
  input wire load,
  input wire [W-1:0] count,
  output wire done
);
  reg [W-1:0] remain;

  always @(posedge clk) begin
    if (sys_rst) begin
      remain <= {W{1'b0}};
    end else if (load) begin
      remain <= count;
    end else if (remain != {W{1'b0}}) begin
      remain <= remain - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign done = (remain == {W{1'b0}}) && !load;
endmodule

// ---- adr_refresh_timer.v ----
// Refresh interval timer raising a request until it is served
`timescale 1ns/10ps
`include "adr_consts.vh"

module adr_refresh_timer #(
  parameter W = `ADR_CNT_BITS,
  parameter [W-1:0] PERIOD = 20'd1
) (
  input wire clk,
  input wire sys_rst,
  input wire served,
  output reg due
);
  reg [W-1:0] tick;

  always @(posedge clk) begin
    if (sys_rst) begin
      tick <= {W{1'b0}};
      due <= 1'b0;
    end else begin
      if (tick >= PERIOD - {{(W-1){1'b0}}, 1'b1}) begin
        tick <= {W{1'b0}};
      end else begin
        tick <= tick + {{(W-1){1'b0}}, 1'b1};
      end
      // Set wins over the clear so no interval is lost
      if (tick >= PERIOD - {{(W-1){1'b0}}, 1'b1}) begin
        due <= 1'b1;
      end else if (served) begin
        due <= 1'b0;
      end
    end
  end
endmodule

// ---- adr_ctrl.v ----
// Controller that drives a multiplexed-strobe dynamic memory
`timescale 1ns/10ps
`include "adr_consts.vh"

// Function
// - 18-bit address as row then column
// - Row on row strobe, then column strobe
// - Cycle ends when both strobes high
// - Hold row strobe high for precharge
// - Never cut strobes short of pulse widths
// - Read keeps store strobe high throughout
// - Input bit valid before later falling edge
// - Early write: store before column strobe
// - Read-modify-write: store after column, data read
// - Refresh every row within each interval
// - Row-only refresh keeps column strobe high
// - Counter refresh: column before row strobe
// - Hidden refresh extends read, cycles row
// - Page mode cycles column strobe, row open
// - Power-up pause, then eight row cycles
// - Idle beyond interval needs eight cycles
module adr_ctrl #(
  parameter CW = `ADR_CNT_BITS,
  parameter [CW-1:0] POWER_UP_CYCLES = `ADR_POWER_UP_PAUSE_US * `ADR_CLK_MHZ,
  parameter [CW-1:0] REFRESH_CYCLES =
    (`ADR_REFRESH_PERIOD_US * `ADR_CLK_MHZ) / `ADR_ROW_COUNT,
  parameter [CW-1:0] IDLE_LIMIT_CYCLES = `ADR_REFRESH_PERIOD_US * `ADR_CLK_MHZ
) (
  input wire clk,
  input wire sys_rst,
  input wire req_valid,
  output wire req_ready,
  input wire [1:0] req_op,
  input wire [`ADR_ADDR_BITS-1:0] req_addr,
  input wire req_wdata,
  input wire req_page,
  input wire req_hidden_refresh,
  output reg rsp_valid,
  output reg rsp_rdata,
  output reg init_done,
  output reg row_strobe_n,
  output reg column_strobe_n,
  output reg store_strobe_n,
  output reg [`ADR_PIN_BITS-1:0] addr_pins,
  output reg serial_input_bit,
  input wire output_bit
);
  // ************************************************************
  // Interval counts
  // ************************************************************
  function [CW-1:0] cyc;
    input integer ps;
    integer t;
    begin
      t = (ps + `ADR_CLK_PERIOD_PS - 1) / `ADR_CLK_PERIOD_PS;
      cyc = t[CW-1:0];
      if (cyc == {CW{1'b0}}) cyc = {{(CW-1){1'b0}}, 1'b1};
    end
  endfunction

  localparam [CW-1:0] T_RP = cyc(`ADR_ROW_PRECHARGE_TIME_PS);
  localparam [CW-1:0] T_RAH = cyc(`ADR_ROW_ADDR_HOLD_PS);
  localparam [CW-1:0] T_RCD = cyc(`ADR_ROW_TO_COLUMN_DELAY_PS);
  localparam [CW-1:0] T_CAS = cyc(`ADR_COLUMN_PULSE_WIDTH_PS);
  localparam [CW-1:0] T_RAS = cyc(`ADR_ROW_PULSE_WIDTH_PS);
  localparam [CW-1:0] T_CP = cyc(`ADR_COLUMN_PRECHARGE_PS);
  localparam [CW-1:0] T_CSR = cyc(`ADR_REFRESH_SETUP_PS);
  localparam [CW-1:0] T_CHR = cyc(`ADR_REFRESH_HOLD_PS);
  localparam [CW-1:0] T_CWD = cyc(`ADR_COLUMN_TO_STORE_DELAY_PS);
  localparam [CW-1:0] T_WP = cyc(`ADR_STORE_PULSE_PS);
  localparam [CW-1:0] T_ACC = cyc(`ADR_ACCESS_FROM_ROW_STROBE_PS);

  // ************************************************************
  // States
  // ************************************************************
  localparam [3:0] S_PWR = 4'h0;
  localparam [3:0] S_INIT = 4'h1;
  localparam [3:0] S_IDLE = 4'h2;
  localparam [3:0] S_ROW = 4'h3;
  localparam [3:0] S_COL = 4'h4;
  localparam [3:0] S_ACC = 4'h5;
  localparam [3:0] S_STORE = 4'h6;
  localparam [3:0] S_CUP = 4'h7;
  localparam [3:0] S_PRE = 4'h8;
  localparam [3:0] S_CBR = 4'h9;
  localparam [3:0] S_CBR_ROW = 4'ha;
  localparam [3:0] S_CBR_END = 4'hb;
  localparam [3:0] S_WAIT_RAS = 4'hc;

  reg [3:0] state;
  reg [1:0] op;
  reg page;
  reg hidden;
  reg [3:0] init_left;
  reg [CW-1:0] idle_cnt;
  reg dq_meta;
  reg dq_sync;
  reg tim_load;
  reg [CW-1:0] tim_count;
  wire tim_done;
  reg ras_load;
  wire ras_done;
  reg refresh_served;
  wire refresh_due;

  adr_interval #(.W(CW)) u_step (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(tim_load),
    .count(tim_count),
    .done(tim_done)
  );

  // Separate timer so row strobe pulse width spans the whole cycle
  adr_interval #(.W(CW)) u_row_width (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(ras_load),
    .count(T_RAS),
    .done(ras_done)
  );

  adr_refresh_timer #(.W(CW), .PERIOD(REFRESH_CYCLES)) u_refresh (
    .clk(clk),
    .sys_rst(sys_rst),
    .served(refresh_served),
    .due(refresh_due)
  );

  // Read bit comes from a pin; two flops before use
  always @(posedge clk) begin
    if (sys_rst) begin
      dq_meta <= 1'b0;
      dq_sync <= 1'b0;
    end else begin
      dq_meta <= output_bit;
      dq_sync <= dq_meta;
    end
  end

  reg [`ADR_PIN_BITS-1:0] row_open;
  reg [`ADR_PIN_BITS-1:0] req_col;

  // Page flag of the previous request keeps the row open for this one
  wire page_hit = page && req_valid && !refresh_due &&
                  (req_addr[`ADR_ADDR_BITS-1:`ADR_PIN_BITS] == row_open);

  // Not ready when idle limit hits, else the request would be dropped
  assign req_ready = init_done && !refresh_due &&
                     ((state == S_IDLE && tim_done && idle_cnt < IDLE_LIMIT_CYCLES) ||
                      (state == S_CUP && tim_done && page_hit));

  // ************************************************************
  // Sequencer
  // ************************************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      state <= S_PWR;
      op <= `ADR_OP_READ;
      page <= 1'b0;
      hidden <= 1'b0;
      init_left <= 4'h0;
      idle_cnt <= {CW{1'b0}};
      init_done <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 1'b0;
      row_strobe_n <= 1'b1;
      column_strobe_n <= 1'b1;
      store_strobe_n <= 1'b1;
      addr_pins <= {`ADR_PIN_BITS{1'b0}};
      serial_input_bit <= 1'b0;
      row_open <= {`ADR_PIN_BITS{1'b0}};
      tim_load <= 1'b1;
      tim_count <= POWER_UP_CYCLES;
      ras_load <= 1'b0;
      refresh_served <= 1'b0;
    end else begin
      tim_load <= 1'b0;
      ras_load <= 1'b0;
      rsp_valid <= 1'b0;
      refresh_served <= 1'b0;
      // Long silence on row strobe forces re-initialisation
      if (state == S_IDLE && row_strobe_n && idle_cnt < IDLE_LIMIT_CYCLES) begin
        idle_cnt <= idle_cnt + {{(CW-1){1'b0}}, 1'b1};
      end else if (!row_strobe_n) begin
        idle_cnt <= {CW{1'b0}};
      end
      case (state)
        S_PWR: begin
          if (tim_done) begin
            init_left <= `ADR_INIT_CYCLES;
            state <= S_INIT;
          end
        end
        S_INIT: begin
          // Row-only cycles at the row left on addr_pins (zero after reset) serve as init cycles
          if (tim_done && row_strobe_n) begin
            if (init_left == 4'h0) begin
              init_done <= 1'b1;
              state <= S_IDLE;
            end else begin
              row_strobe_n <= 1'b0;
              ras_load <= 1'b1;
              tim_load <= 1'b1;
              tim_count <= T_RAS;
              init_left <= init_left - 4'h1;
            end
          end else if (tim_done) begin
            row_strobe_n <= 1'b1;
            tim_load <= 1'b1;
            tim_count <= T_RP;
          end
        end
        S_IDLE: begin
          page <= 1'b0;
          if (idle_cnt >= IDLE_LIMIT_CYCLES) begin
            init_done <= 1'b0;
            init_left <= `ADR_INIT_CYCLES;
            idle_cnt <= {CW{1'b0}};
            state <= S_INIT;
          end else if (tim_done && refresh_due) begin
            column_strobe_n <= 1'b0;
            tim_load <= 1'b1;
            tim_count <= T_CSR;
            state <= S_CBR;
          end else if (req_ready && req_valid) begin
            op <= req_op;
            page <= req_page;
            hidden <= req_hidden_refresh && req_op == `ADR_OP_READ;
            addr_pins <= req_addr[`ADR_ADDR_BITS-1:`ADR_PIN_BITS];
            row_open <= req_addr[`ADR_ADDR_BITS-1:`ADR_PIN_BITS];
            serial_input_bit <= req_wdata;
            store_strobe_n <= (req_op != `ADR_OP_WRITE);
            row_strobe_n <= 1'b0;
            ras_load <= 1'b1;
            tim_load <= 1'b1;
            tim_count <= T_RAH;
            state <= S_ROW;
          end
        end
        S_ROW: begin
          if (tim_done) begin
            addr_pins <= req_col;
            tim_load <= 1'b1;
            tim_count <= T_RCD - T_RAH;
            state <= S_COL;
          end
        end
        S_COL: begin
          if (tim_done) begin
            column_strobe_n <= 1'b0;
            tim_load <= 1'b1;
            // Early edge keeps access measured from row strobe
            tim_count <= (op == `ADR_OP_WRITE) ? T_CAS : T_ACC;
            state <= S_ACC;
          end
        end
        S_ACC: begin
          if (tim_done) begin
            if (op != `ADR_OP_WRITE) begin
              rsp_valid <= 1'b1;
              rsp_rdata <= dq_sync;
            end
            if (op == `ADR_OP_RMW) begin
              store_strobe_n <= 1'b0;
              tim_load <= 1'b1;
              tim_count <= T_WP + T_CWD;
              state <= S_STORE;
            end else if (hidden) begin
              row_strobe_n <= 1'b1;
              hidden <= 1'b0;
              tim_load <= 1'b1;
              tim_count <= T_RP;
              state <= S_CBR;
            end else begin
              state <= S_STORE;
            end
          end
        end
        S_STORE: begin
          // Column strobe rises only after both pulse widths met
          if (tim_done) begin
            column_strobe_n <= 1'b1;
            store_strobe_n <= 1'b1;
            tim_load <= 1'b1;
            tim_count <= T_CP;
            state <= S_CUP;
          end
        end
        S_CUP: begin
          if (page_hit && tim_done && req_valid) begin
            op <= req_op;
            page <= req_page;
            serial_input_bit <= req_wdata;
            store_strobe_n <= (req_op != `ADR_OP_WRITE);
            addr_pins <= req_addr[`ADR_PIN_BITS-1:0];
            tim_load <= 1'b1;
            tim_count <= {{(CW-1){1'b0}}, 1'b1};
            state <= S_COL;
          end else if (tim_done && (!page || !req_valid || !page_hit)) begin
            state <= S_WAIT_RAS;
          end
        end
        S_WAIT_RAS: begin
          if (ras_done) begin
            row_strobe_n <= 1'b1;
            tim_load <= 1'b1;
            tim_count <= T_RP;
            state <= S_PRE;
          end
        end
        S_PRE: begin
          page <= 1'b0;
          state <= S_IDLE;
        end
        S_CBR: begin
          if (tim_done) begin
            row_strobe_n <= 1'b0;
            ras_load <= 1'b1;
            tim_load <= 1'b1;
            tim_count <= T_CHR;
            refresh_served <= 1'b1;
            state <= S_CBR_ROW;
          end
        end
        S_CBR_ROW: begin
          if (tim_done) begin
            column_strobe_n <= 1'b1;
            tim_load <= 1'b1;
            tim_count <= T_CP;
            state <= S_CBR_END;
          end
        end
        S_CBR_END: begin
          if (tim_done) begin
            state <= S_WAIT_RAS;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Column half held from the accepted request
  always @(posedge clk) begin
    if (sys_rst) begin
      req_col <= {`ADR_PIN_BITS{1'b0}};
    end else if (state == S_IDLE && req_ready && req_valid) begin
      req_col <= req_addr[`ADR_PIN_BITS-1:0];
    end
  end
endmodule

// ---- adr_ctrl_asserts.sv ----
// Checker for strobe order and interval timing of the memory controller
`timescale 1ns/10ps
`include "adr_consts.vh"
module adr_ctrl_asserts #(
  parameter CW = `ADR_CNT_BITS,
  parameter [CW-1:0] POWER_UP_CYCLES = 20'd1,
  parameter [CW-1:0] REFRESH_CYCLES = 20'd1
) (
  input wire clk,
  input wire sys_rst,
  input wire req_ready,
  input wire init_done,
  input wire row_strobe_n,
  input wire column_strobe_n,
  input wire store_strobe_n,
  input wire [`ADR_PIN_BITS-1:0] addr_pins,
  input wire serial_input_bit
);
  // ****************************************
  // Helper counters
  // ****************************************
  localparam int PRE = 10;
  localparam int RPW = 10;
  // Refresh may wait behind one open page
  localparam int SLACK = 128;
  logic [CW-1:0] hi_n;
  logic [CW-1:0] lo_n;
  logic [CW-1:0] gap;
  logic [CW-1:0] up;
  logic [3:0] rows;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  always @(posedge clk) begin
    if (sys_rst) begin
      hi_n <= PRE;
      lo_n <= '0;
      gap <= '0;
      up <= '0;
      rows <= 4'h0;
    end else begin
      hi_n <= !row_strobe_n ? '0 : (hi_n < PRE) ? hi_n + 1'b1 : hi_n;
      lo_n <= row_strobe_n ? '0 : (lo_n < RPW) ? lo_n + 1'b1 : lo_n;
      gap <= $fell(row_strobe_n) ? '0 : gap + 1'b1;
      up <= (up < POWER_UP_CYCLES) ? up + 1'b1 : up;
      rows <= ($fell(row_strobe_n) && rows < 4'h8) ? rows + 4'h1 : rows;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  sequence s_row_open;
    $fell(row_strobe_n) && column_strobe_n;
  endsequence
  sequence s_cbr_start;
    $fell(row_strobe_n) && !column_strobe_n;
  endsequence
  sequence s_col_fall;
    $fell(column_strobe_n) && !row_strobe_n;
  endsequence
  property p_precharge;
    $fell(row_strobe_n) |-> hi_n >= PRE;
  endproperty
  a_precharge: assert property (p_precharge) else $error("short precharge");
  property p_row_width;
    $rose(row_strobe_n) |-> lo_n >= RPW;
  endproperty
  a_row_width: assert property (p_row_width) else $error("short row pulse");
  property p_col_width;
    $fell(column_strobe_n) |-> !column_strobe_n [*4];
  endproperty
  a_col_width: assert property (p_col_width) else $error("short column pulse");
  property p_row_hold;
    s_row_open |=> $stable(addr_pins);
  endproperty
  a_row_hold: assert property (p_row_hold) else $error("row address hold");
  property p_rcd;
    s_col_fall |-> $past(row_strobe_n, 4) == 1'b0;
  endproperty
  a_rcd: assert property (p_rcd) else $error("column strobe too early");
  property p_col_addr;
    s_col_fall |-> $stable(addr_pins);
  endproperty
  a_col_addr: assert property (p_col_addr) else $error("column address moved");
  property p_cbr_setup;
    s_cbr_start |-> $past(column_strobe_n, 2) == 1'b0;
  endproperty
  a_cbr_setup: assert property (p_cbr_setup) else $error("refresh setup");
  property p_wdata;
    ($fell(column_strobe_n) && !store_strobe_n) || ($fell(store_strobe_n) && !column_strobe_n)
      |-> $stable(serial_input_bit);
  endproperty
  a_wdata: assert property (p_wdata) else $error("write bit late");
  property p_pause;
    $fell(row_strobe_n) |-> up >= POWER_UP_CYCLES;
  endproperty
  a_pause: assert property (p_pause) else $error("row cycle in pause");
  property p_init;
    $rose(init_done) |-> rows == 4'h8;
  endproperty
  a_init: assert property (p_init) else $error("init cycle count");
  property p_no_take;
    !init_done |-> !req_ready;
  endproperty
  a_no_take: assert property (p_no_take) else $error("ready before init");
  property p_refresh;
    init_done |-> gap < REFRESH_CYCLES + SLACK;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh gap");
endmodule

// ---- adr_mem_model.sv ----
// Behavioural model of the strobed one-bit memory
`timescale 1ns/10ps
module adr_mem_model (
  input wire row_strobe_n,
  input wire column_strobe_n,
  input wire store_strobe_n,
  input wire [8:0] addr_pins,
  input wire serial_input_bit,
  output wire output_bit
);
  // ****************************************
  // Array and output
  // ****************************************
  bit mem [0:262143];
  logic [8:0] row = 9'h000;
  logic [17:0] a = 18'h00000;
  bit drv;
  bit dq;
  int cbr;
  int hid;
  time t_row;
  // Released pin shows the inverse, so a stale sample cannot match
  assign output_bit = drv ? dq : !dq;
  always @(negedge row_strobe_n) begin
    t_row = $time;
    // Let address and strobes launched on the same edge settle
    #1;
    if (column_strobe_n) begin
      row = addr_pins;
    end else begin
      cbr++;
      hid += drv;
    end
  end
  always @(negedge column_strobe_n) begin
    if (!row_strobe_n) begin
      a = {row, addr_pins};
      if (!store_strobe_n) begin
        mem[a] = serial_input_bit;
      end else begin
        #30;
        if ($time - t_row < 80) #(80 - ($time - t_row));
        dq = mem[a];
        drv = !column_strobe_n;
      end
    end
  end
  always @(negedge store_strobe_n) begin
    if (!column_strobe_n && !row_strobe_n) begin
      mem[a] = serial_input_bit;
    end
  end
  always @(posedge column_strobe_n) begin
    drv = 1'b0;
  end
endmodule

// ---- testbench.sv ----
// Self-checking bench for the strobe memory controller
`timescale 1ns/10ps
`include "adr_consts.vh"
module testbench;
  localparam int RF = 200;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic [1:0] req_op = 2'h0;
  logic [`ADR_ADDR_BITS-1:0] req_addr = 18'h00000;
  logic req_wdata = 1'b0;
  logic req_page = 1'b0;
  logic req_hidden_refresh = 1'b0;
  wire req_ready, rsp_valid, rsp_rdata, init_done;
  wire row_strobe_n, column_strobe_n, store_strobe_n, serial_input_bit, output_bit;
  wire [`ADR_PIN_BITS-1:0] addr_pins;
  int n_fail = 0;
  int comparisons = 0;
  int n_rows = 0;
  int seed;
  int k;
  int i;
  int h;
  logic [17:0] ad;
  bit shadow [0:262143];
  adr_ctrl #(.POWER_UP_CYCLES(20'd20), .REFRESH_CYCLES(20'd200),
    .IDLE_LIMIT_CYCLES(20'd2000)) i_dut (.clk, .sys_rst, .req_valid, .req_ready,
    .req_op, .req_addr, .req_wdata, .req_page, .req_hidden_refresh, .rsp_valid,
    .rsp_rdata, .init_done, .row_strobe_n, .column_strobe_n, .store_strobe_n,
    .addr_pins, .serial_input_bit, .output_bit);
  adr_mem_model i_mem (.row_strobe_n, .column_strobe_n, .store_strobe_n, .addr_pins,
    .serial_input_bit, .output_bit);
  initial forever #4 clk = ~clk;
  always @(negedge row_strobe_n) n_rows++;
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic req(input logic [1:0] o, input logic [17:0] a, input logic d, p, hr);
    int n;
    @(negedge clk);
    req_op = o;
    req_addr = a;
    req_wdata = d;
    req_page = p;
    req_hidden_refresh = hr;
    req_valid = 1'b1;
    // Let a combinational ready settle before judging it
    #1;
    for (n = 0; n < 400 && req_ready !== 1'b1; n++) @(negedge clk);
    if (n == 400) n_fail++;
    @(negedge clk);
    req_valid = 1'b0;
    if (o == `ADR_OP_WRITE) begin
      shadow[a] = d;
    end else begin
      for (n = 0; n < 100 && rsp_valid !== 1'b1; n++) @(negedge clk);
      if (n == 100) n_fail++;
      check(rsp_rdata, shadow[a]);
      if (o == `ADR_OP_RMW) shadow[a] = d;
    end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 32'h6c6a0bf2;
    repeat (16) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    check(init_done, 1'b0);
    for (k = 0; k < 2000 && init_done !== 1'b1; k++) @(negedge clk);
    check(n_rows, 8);
    for (i = 0; i < 30; i++) begin
      ad = (i == 0) ? 18'h00000 : (i == 1) ? 18'h3ffff : 18'($random(seed));
      req(2'({$random(seed)} % 3), ad, 1'($random(seed)), 1'b0, 1'b0);
      req(`ADR_OP_READ, ad, 1'b0, 1'b0, 1'b0);
    end
    // Start the page just after a refresh so none cuts it
    h = n_rows;
    for (k = 0; k < 400 && n_rows == h; k++) @(negedge clk);
    repeat (12) @(negedge clk);
    h = n_rows;
    req(`ADR_OP_WRITE, 18'h0a405, 1'b1, 1'b1, 1'b0);
    req(`ADR_OP_RMW, 18'h0a40a, 1'b1, 1'b1, 1'b0);
    req(`ADR_OP_READ, 18'h0a405, 1'b0, 1'b0, 1'b0);
    check(n_rows - h, 1);
    h = i_mem.hid;
    req(`ADR_OP_READ, 18'h0a40a, 1'b0, 1'b0, 1'b1);
    for (k = 0; k < 100 && i_mem.hid == h; k++) @(negedge clk);
    check(i_mem.hid, h + 1);
    h = n_rows;
    repeat (3 * RF) @(negedge clk);
    check(n_rows - h >= 2, 1);
    req(`ADR_OP_READ, 18'h0a405, 1'b0, 1'b0, 1'b0);
    report_and_stop();
  end
  initial begin
    // Whole sequence needs well under 8000 cycles
    #(40000 * 8);
    n_fail++;
    report_and_stop();
  end
endmodule
bind adr_ctrl adr_ctrl_asserts #(.CW(CW), .POWER_UP_CYCLES(POWER_UP_CYCLES),
  .REFRESH_CYCLES(REFRESH_CYCLES)) i_chk (.clk, .sys_rst, .req_ready, .init_done,
  .row_strobe_n, .column_strobe_n, .store_strobe_n, .addr_pins, .serial_input_bit);
